// File: hdl/iod_out_regs.sv
// Output data registers of the inertial unit, read over the serial port.
// Assumes serial mode 3, 16-bit frames, sclk below a quarter of ref_clk.
//
// Overview of operation
// - The z rate low word at 0x0c holds the extra bits below the high word.
// - The z rate high word at 0x0e is twos complement with zero at 0x0000.
// - Each accel axis joins its high and low words into a 32-bit value.
// - The x accel low word at 0x10 holds the extra x resolution bits.
// - The x accel high word at 0x12 is twos complement, 12.25 mm/s2 a step.
// - The y accel words sit at 0x14 and 0x16, coded like the x pair.
// - The z accel words sit at 0x18 and 0x1a, coded like the x pair.
// - The z accel high word is twos complement, 12.25 mm/s2 a step.
// - The rate step is 0.00625, 0.025 or 0.1 deg/s by model variant.
// - The temperature word at 0x1c is twos complement, 0.1 degC a step.
`include "iod_cfg.svh"
`default_nettype none

module iod_out_regs (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        spi_sclk,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    output logic             spi_miso_oe_n,
    input  wire logic        upd_strobe,
    input  wire logic [31:0] upd_z_rate,
    input  wire logic [31:0] upd_x_accel,
    input  wire logic [31:0] upd_y_accel,
    input  wire logic [31:0] upd_z_accel,
    input  wire logic [15:0] upd_temp
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [2:0] pin_sync;
    logic [2:0] pin_prev;
    logic       cs_n_s;
    logic       mosi_s;
    logic       sclk_rise;
    logic       sclk_fall;

    iod_pin_sync #(
        .W       (3),
        .RST_VAL (3'h7)
    ) u_sync (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .pin_in   ({spi_cs_n, spi_sclk, spi_mosi}),
        .pin_sync (pin_sync),
        .pin_prev (pin_prev)
    );

    assign cs_n_s    = pin_sync[2];
    assign mosi_s    = pin_sync[0];
    assign sclk_rise = pin_sync[1] & ~pin_prev[1];
    assign sclk_fall = ~pin_sync[1] & pin_prev[1];

    ////////////////////////////////////////////////////////////////////////
    // Sample bank

    iod_rd_if rd ();

    iod_sample_bank u_bank (
        .ref_clk     (ref_clk),
        .sys_rst     (sys_rst),
        .upd_strobe  (upd_strobe),
        .upd_z_rate  (upd_z_rate),
        .upd_x_accel (upd_x_accel),
        .upd_y_accel (upd_y_accel),
        .upd_z_accel (upd_z_accel),
        .upd_temp    (upd_temp),
        .rd          (rd.bank)
    );

    ////////////////////////////////////////////////////////////////////////
    // Frame engine

    iod_pkg::iod_state_t state;
    iod_pkg::iod_state_t next_state;
    logic [3:0]          bit_cnt;
    logic [3:0]          next_bit_cnt;
    logic [15:0]         rx_sr;
    logic [15:0]         next_rx_sr;
    logic [15:0]         tx_sr;
    logic [15:0]         next_tx_sr;
    iod_pkg::iod_word_t  pend_word;
    iod_pkg::iod_word_t  next_pend_word;
    logic                next_miso;
    logic                next_miso_oe_n;
    logic [15:0]         rx_word;
    logic                frame_end;
    logic                read_hit;
    logic [6:0]          rx_addr;

    assign rx_word   = {rx_sr[14:0], mosi_s};
    assign rx_addr   = rx_word[`IOD_ADDR_MSB:`IOD_ADDR_LSB];
    assign frame_end = (state == iod_pkg::IOD_SHIFT) && !cs_n_s
                       && sclk_rise && (bit_cnt == `IOD_FRAME_LAST);
    assign read_hit  = frame_end && !rx_word[`IOD_RW_BIT];
    assign rd.addr   = rx_addr;

    always_comb
    begin
        next_state     = state;
        next_bit_cnt   = bit_cnt;
        next_rx_sr     = rx_sr;
        next_tx_sr     = tx_sr;
        next_pend_word = pend_word;
        next_miso      = spi_miso;
        next_miso_oe_n = spi_miso_oe_n;
        case (state)
            iod_pkg::IOD_IDLE:
            begin
                if (!cs_n_s)
                begin
                    // Answer to the previous frame's read goes out now
                    next_state     = iod_pkg::IOD_SHIFT;
                    next_bit_cnt   = 4'h0;
                    next_tx_sr     = pend_word;
                    next_miso      = pend_word[15];
                    next_miso_oe_n = 1'b0;
                end
            end
            iod_pkg::IOD_SHIFT:
            begin
                if (cs_n_s)
                begin
                    // Short frame: drop it and any answer it owed
                    next_state     = iod_pkg::IOD_IDLE;
                    next_miso_oe_n = 1'b1;
                    next_pend_word = `IOD_WORD_RST;
                end
                else
                begin
                    if (sclk_fall)
                    begin
                        next_miso  = tx_sr[15];
                        next_tx_sr = {tx_sr[14:0], 1'b0};
                    end
                    if (sclk_rise)
                    begin
                        next_rx_sr   = rx_word;
                        next_bit_cnt = 4'(bit_cnt + 4'h1);
                    end
                    if (frame_end)
                    begin
                        next_state = iod_pkg::IOD_DONE;
                        if (rx_word[`IOD_RW_BIT])
                            next_pend_word = `IOD_WORD_RST;
                        else
                            next_pend_word = rd.word;
                    end
                end
            end
            iod_pkg::IOD_DONE:
            begin
                // Extra clocks in a long frame are ignored
                if (cs_n_s)
                begin
                    next_state     = iod_pkg::IOD_IDLE;
                    next_miso_oe_n = 1'b1;
                end
            end
            default:
            begin
                next_state     = iod_pkg::IOD_IDLE;
                next_miso_oe_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state         <= iod_pkg::IOD_IDLE;
            bit_cnt       <= 4'h0;
            rx_sr         <= 16'h0000;
            tx_sr         <= 16'h0000;
            pend_word     <= `IOD_WORD_RST;
            spi_miso      <= 1'b0;
            spi_miso_oe_n <= 1'b1;
        end
        else
        begin
            state         <= next_state;
            bit_cnt       <= next_bit_cnt;
            rx_sr         <= next_rx_sr;
            tx_sr         <= next_tx_sr;
            pend_word     <= next_pend_word;
            spi_miso      <= next_miso;
            spi_miso_oe_n <= next_miso_oe_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Mirror of the last update, read only by the checks
    logic [31:0] chk_z_rate;
    logic [31:0] chk_x_acc;
    logic [31:0] chk_y_acc;
    logic [31:0] chk_z_acc;
    logic [15:0] chk_temp;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            chk_z_rate <= 32'h0000_0000;
            chk_x_acc  <= 32'h0000_0000;
            chk_y_acc  <= 32'h0000_0000;
            chk_z_acc  <= 32'h0000_0000;
            chk_temp   <= 16'h0000;
        end
        else if (upd_strobe)
        begin
            chk_z_rate <= upd_z_rate;
            chk_x_acc  <= upd_x_accel;
            chk_y_acc  <= upd_y_accel;
            chk_z_acc  <= upd_z_accel;
            chk_temp   <= upd_temp;
        end
    end

    z_rate_lo_a:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        (read_hit && rx_addr[6:1] == `IOD_OFS_Z_RATE_LO >> 1)
        |=> pend_word == $past(chk_z_rate[15:0]))
    else $error("Rate low word read wrong");

    z_rate_hi_a:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        (read_hit && rx_addr == `IOD_OFS_Z_RATE_HI)
        |=> pend_word == $past(chk_z_rate[31:16]))
    else $error("Rate high word read wrong");

    x_acc_lo_a:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        (read_hit && rx_addr == `IOD_OFS_X_ACC_LO)
        |=> pend_word == $past(chk_x_acc[15:0]))
    else $error("X accel low word read wrong");

    x_acc_hi_a:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        (read_hit && rx_addr == `IOD_OFS_X_ACC_HI)
        |=> pend_word == $past(chk_x_acc[31:16]))
    else $error("X accel high word read wrong");

    y_acc_pair_a:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        (read_hit && rx_addr[6:2] == `IOD_OFS_Y_ACC_LO >> 2)
        |=> pend_word == ($past(rx_addr[1]) ? $past(chk_y_acc[31:16])
                                            : $past(chk_y_acc[15:0])))
    else $error("Y accel word read wrong");

    z_acc_lo_a:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        (read_hit && rx_addr == `IOD_OFS_Z_ACC_LO)
        |=> pend_word == $past(chk_z_acc[15:0]))
    else $error("Z accel low word read wrong");

    z_acc_hi_a:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        (read_hit && rx_addr == `IOD_OFS_Z_ACC_HI)
        |=> pend_word == $past(chk_z_acc[31:16]))
    else $error("Z accel high word read wrong");

    temp_word_a:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        (read_hit && rx_addr == `IOD_OFS_TEMP)
        |=> pend_word == $past(chk_temp))
    else $error("Temperature word read wrong");

    write_ignored_a:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        (frame_end && rx_word[`IOD_RW_BIT])
        |=> pend_word == `IOD_WORD_RST && state == iod_pkg::IOD_DONE
            ##1 pend_word == `IOD_WORD_RST)
    else $error("Write frame produced data");

    answer_loaded_a:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == iod_pkg::IOD_IDLE && !cs_n_s)
        |=> !spi_miso_oe_n && tx_sr == $past(pend_word)
            && spi_miso == $past(pend_word[15]))
    else $error("Answer not loaded at frame start");

    miso_released_a:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        state == iod_pkg::IOD_IDLE |-> spi_miso_oe_n)
    else $error("Data out driven between frames");

    short_frame_a:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == iod_pkg::IOD_SHIFT && cs_n_s)
        |=> state == iod_pkg::IOD_IDLE && pend_word == `IOD_WORD_RST)
    else $error("Cut frame left an answer");

    unmapped_zero_a:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        (read_hit && (rx_addr < `IOD_OFS_Z_RATE_LO
                      || rx_addr > `IOD_OFS_LAST))
        |=> pend_word == `IOD_WORD_RST)
    else $error("Unmapped read produced data");

endmodule // iod_out_regs

`default_nettype wire

// File: hdl/iod_cfg.svh
// Register map, frame layout and reset values of the output data block.
// Assumes byte addresses of seven bits taken from the serial command word.
`ifndef IOD_CFG_SVH
`define IOD_CFG_SVH

`define IOD_OFS_Z_RATE_LO 7'h0c
`define IOD_OFS_Z_RATE_HI 7'h0e
`define IOD_OFS_X_ACC_LO  7'h10
`define IOD_OFS_X_ACC_HI  7'h12
`define IOD_OFS_Y_ACC_LO  7'h14
`define IOD_OFS_Y_ACC_HI  7'h16
`define IOD_OFS_Z_ACC_LO  7'h18
`define IOD_OFS_Z_ACC_HI  7'h1a
`define IOD_OFS_TEMP      7'h1c
`define IOD_OFS_LAST      7'h1d

`define IOD_RW_BIT        15
`define IOD_ADDR_MSB      14
`define IOD_ADDR_LSB      8
`define IOD_FRAME_LAST    4'hf

`define IOD_WORD_RST      16'h0000
`define IOD_SLOTS         9
`define IOD_SLOT_NONE     4'hf

`endif

// File: hdl/iod_pkg.sv
// Types and the address decode shared by the output data block.
// Assumes iod_cfg.svh is on the include path.
`include "iod_cfg.svh"
`default_nettype none

package iod_pkg;

    typedef logic [15:0] iod_word_t;

    typedef enum logic [1:0] {
        IOD_IDLE  = 2'b00,
        IOD_SHIFT = 2'b01,
        IOD_DONE  = 2'b10
    } iod_state_t;

    // Either byte address of a word pair selects the same slot
    function automatic logic [3:0] iod_slot(input logic [6:0] addr);
        logic [6:0] rel;
        rel = addr - `IOD_OFS_Z_RATE_LO;
        if (addr >= `IOD_OFS_Z_RATE_LO && addr <= `IOD_OFS_LAST)
            return rel[4:1];
        return `IOD_SLOT_NONE;
    endfunction

endpackage

`default_nettype wire

// File: hdl/iod_rd_if.sv
// Read port between the frame engine and the sample bank.
// Assumes the bank answers combinationally in the same cycle.
`default_nettype none

interface iod_rd_if;
    logic [6:0]        addr;
    iod_pkg::iod_word_t word;

    modport bank (input addr, output word);
    modport user (output addr, input word);
endinterface

`default_nettype wire

// File: hdl/iod_pin_sync.sv
// Two-stage synchroniser for pins plus one stage for edge detection.
// Assumes pins are asynchronous to ref_clk.
`default_nettype none

module iod_pin_sync #(
    parameter int         W       = 3,
    parameter logic [2:0] RST_VAL = 3'h7
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync,
    output logic      [W-1:0] pin_prev
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;
    logic [W-1:0] next_prev;

    always_comb
    begin
        next_meta = pin_in;
        next_sync = meta;
        next_prev = pin_sync;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            meta     <= RST_VAL[W-1:0];
            pin_sync <= RST_VAL[W-1:0];
            pin_prev <= RST_VAL[W-1:0];
        end
        else
        begin
            meta     <= next_meta;
            pin_sync <= next_sync;
            pin_prev <= next_prev;
        end
    end

endmodule // iod_pin_sync

`default_nettype wire

// File: hdl/iod_sample_bank.sv
// Holds the output words of one data update and answers reads.
// Assumes upd_strobe comes from logic on ref_clk.
`include "iod_cfg.svh"
`default_nettype none

module iod_sample_bank (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        upd_strobe,
    input  wire logic [31:0] upd_z_rate,
    input  wire logic [31:0] upd_x_accel,
    input  wire logic [31:0] upd_y_accel,
    input  wire logic [31:0] upd_z_accel,
    input  wire logic [15:0] upd_temp,
    iod_rd_if.bank           rd
);

    iod_pkg::iod_word_t in_word [`IOD_SLOTS];
    iod_pkg::iod_word_t word    [`IOD_SLOTS];
    logic [3:0]         slot;

    // Low word below, high word above: one 32-bit value per axis
    assign in_word[0] = upd_z_rate[15:0];
    assign in_word[1] = upd_z_rate[31:16];
    assign in_word[2] = upd_x_accel[15:0];
    assign in_word[3] = upd_x_accel[31:16];
    assign in_word[4] = upd_y_accel[15:0];
    assign in_word[5] = upd_y_accel[31:16];
    assign in_word[6] = upd_z_accel[15:0];
    assign in_word[7] = upd_z_accel[31:16];
    assign in_word[8] = upd_temp;

    // All slots load on one strobe so pairs never mix updates
    for (genvar i = 0; i < `IOD_SLOTS; i++)
    begin : g_slot
        iod_pkg::iod_word_t next_word;

        always_comb
        begin
            next_word = upd_strobe ? in_word[i] : word[i];
        end

        always_ff @(posedge ref_clk)
        begin
            if (sys_rst)
                word[i] <= `IOD_WORD_RST;
            else
                word[i] <= next_word;
        end
    end

    always_comb
    begin
        slot    = iod_pkg::iod_slot(rd.addr);
        rd.word = `IOD_WORD_RST;
        if (slot < 4'(`IOD_SLOTS))
            rd.word = word[slot];
    end

    pair_coherent_a:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        upd_strobe |=> {word[7], word[6]} == $past(upd_z_accel)
                    && {word[1], word[0]} == $past(upd_z_rate))
    else $error("Word pair not loaded from one update");

endmodule // iod_sample_bank

`default_nettype wire

// File: test/iod_spi_host.sv
// Host side of the serial register port: mode 3, 16-bit frames.
// Assumes ref_clk is the device clock; edges are timed in its cycles.
`default_nettype none

module iod_spi_host (
    input  wire logic ref_clk,
    input  wire logic spi_miso,
    input  wire logic spi_miso_oe_n,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi
);
    timeunit 1ns;
    timeprecision 100ps;

    // Five cycles a half period keeps clear of the three-cycle sync lag
    localparam int HALF = 5;

    initial
    begin
        spi_sclk = 1'b1;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Clock stands high outside frames; data line toggles once released
    task automatic frame(input logic [15:0] cmd, input int nbits,
                         output logic [15:0] rx, output logic oe_ok);
        rx = 16'h0000;
        oe_ok = 1'b1;
        wait_clk(1);
        spi_cs_n = 1'b0;
        wait_clk(HALF);
        for (int i = 0; i < nbits; i++)
        begin
            spi_sclk = 1'b0;
            // Bits past the command word carry zeros
            spi_mosi = (i < 16) ? cmd[15 - i] : 1'b0;
            wait_clk(HALF);
            spi_sclk = 1'b1;
            // A released line reads as the inverse of the last bit
            rx = {rx[14:0], spi_miso_oe_n ? ~spi_miso : spi_miso};
            oe_ok = oe_ok & ~spi_miso_oe_n;
            wait_clk(HALF);
        end
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        wait_clk(HALF);
    endtask
endmodule // iod_spi_host

`default_nettype wire

// File: test/tb_inertial_output_data_registers.sv
// Self-checking bench for the output data registers.
// Assumes iod_spi_host as the serial host and iod_out_regs as the device.
`default_nettype none

module tb_inertial_output_data_registers;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk;
    logic        sys_rst;
    logic        spi_sclk;
    logic        spi_cs_n;
    logic        spi_mosi;
    logic        spi_miso;
    logic        spi_miso_oe_n;
    logic        upd_strobe;
    logic [31:0] upd_z_rate;
    logic [31:0] upd_x_accel;
    logic [31:0] upd_y_accel;
    logic [31:0] upd_z_accel;
    logic [15:0] upd_temp;
    int          fails = 0;
    int          num_checks = 0;
    integer      seed = 32'h8076;
    int          mdl [9];
    int          pend = 0;
    logic [15:0] rx;
    logic [15:0] ex;

    iod_out_regs i_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n), .upd_strobe(upd_strobe),
        .upd_z_rate(upd_z_rate), .upd_x_accel(upd_x_accel),
        .upd_y_accel(upd_y_accel), .upd_z_accel(upd_z_accel),
        .upd_temp(upd_temp)
    );

    iod_spi_host i_host (
        .ref_clk(ref_clk), .spi_miso(spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Word at a byte address; both bytes of a pair give one word
    function automatic int expw(input logic [6:0] a);
        if (a < 7'h0c || a > 7'h1d)
            return 0;
        return mdl[(a - 7'h0c) >> 1];
    endfunction

    // Answers lag one frame; writes and short frames leave zero pending
    task automatic xfer(input logic [15:0] cmd, input int nbits,
                        output logic [15:0] got, output logic [15:0] exp);
        logic ok;
        i_host.frame(cmd, nbits, got, ok);
        exp = 16'(pend);
        check({15'h0000, ok}, 16'h0001);
        pend = (nbits >= 16 && !cmd[15]) ? expw(cmd[14:8]) : 0;
    endtask

    task automatic rd(input logic [6:0] a);
        xfer({1'b0, a, 8'($random(seed))}, 16, rx, ex);
    endtask

    task automatic load(input logic [31:0] zr, input logic [31:0] xa,
                        input logic [31:0] ya, input logic [31:0] za,
                        input logic [15:0] t);
        {upd_z_rate, upd_x_accel, upd_y_accel, upd_z_accel} =
            {zr, xa, ya, za};
        upd_temp = t;
        upd_strobe = 1'b1;
        @(posedge ref_clk);
        #1;
        upd_strobe = 1'b0;
        mdl = '{zr[15:0], zr[31:16], xa[15:0], xa[31:16], ya[15:0],
                ya[31:16], za[15:0], za[31:16], t};
        // Inputs wander after the pulse; held words must not follow
        {upd_z_rate, upd_x_accel} = {$random(seed), $random(seed)};
        {upd_y_accel, upd_z_accel} = {$random(seed), $random(seed)};
        upd_temp = 16'($random(seed));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #5_000_000;
        fails++;
        results();
    end

    initial
    begin
        sys_rst = 1'b1;
        upd_strobe = 1'b0;
        {upd_z_rate, upd_x_accel, upd_y_accel, upd_z_accel} = '0;
        upd_temp = 16'h0000;
        mdl = '{default: 0};
        repeat (3) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        check({14'h0, spi_miso, spi_miso_oe_n}, 16'h0001);
        $display("test reset done");

        for (int n = 0; n < 2; n++)
        begin
            load($random(seed), $random(seed), $random(seed),
                 $random(seed), 16'($random(seed)));
            for (int a = 8'h0c; a <= 8'h1e; a++)
            begin
                rd(7'(a));
                check(rx, ex);
            end
        end
        $display("test map done");

        load(32'h7d000000, 32'h83000000, 32'hffffffff, 32'h00000001,
             16'hfe70);
        foreach (mdl[i])
        begin
            rd(7'h0c + 7'(2 * i));
            check(rx, ex);
        end
        $display("test signed done");

        xfer(16'h92a5, 16, rx, ex);
        check(rx, ex);
        rd(7'h12);
        check(rx, ex);
        xfer(16'h1300, 8, rx, ex);
        rd(7'h13);
        check(rx, ex);
        foreach (mdl[i])
        begin
            rd(7'h0c + 7'(2 * i) + 7'h01);
            check(rx, ex);
        end
        // Long frame: clocks past the sixteenth are ignored
        xfer(16'h9000, 16, rx, ex);
        check(rx, ex);
        xfer({1'b0, 7'h16, 8'h00}, 20, rx, ex);
        check(rx, ex);
        rd(7'h00);
        check(rx, ex);
        $display("test write done");

        rd(7'h0b);
        check(rx, ex);
        rd(7'h1e);
        check(rx, ex);
        rd(7'h7f);
        check(rx, ex);
        rd(7'h10);
        check(rx, ex);
        load(32'h12345678, 32'h9abcdef0, 32'h0, 32'h0, 16'h041a);
        rd(7'h12);
        check(rx, ex);
        rd(7'h1d);
        check(rx, ex);
        rd(7'h0d);
        check(rx, ex);
        rd(7'h0e);
        check(rx, ex);
        rd(7'h00);
        check(rx, ex);
        $display("test pairing done");
        results();
    end
endmodule // tb_inertial_output_data_registers

`default_nettype wire
